// ==== design/cbr_top.sv ====
// Authenticated configuration block read: takes the request frame, prepares
// the response with its code, delivers it on the next retrieve command.
// Assumes all inputs synchronous to clk; MAC engine and write path live outside.
// Behaviour
// - Response frame: type 0700h, count 01h, nonce, data, code, counter, result.
// - Block counter is its own input, not target 0's, and is reported.
// - Code covers response type, nonce, address, data and result bytes.
// - Failed code computation gives result 0002h.
// - A bad request byte, or an error before the result bytes enter the code, gives result 0001h.
// - Response code below byte 223, result 253:252, type 255:254, data 767:256.
module cbr_top #(
  parameter int MAC_BYTES = cbr_pkg::MAC_BYTES_DEF
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic req_valid,
  input wire logic [7:0] req_byte,
  input wire logic req_last,
  output logic req_ready,
  output logic send_done,
  input wire logic rcv_cmd,
  output logic rsp_valid,
  output logic [7:0] rsp_byte,
  output logic rsp_last,
  input wire logic rsp_ready,
  input wire logic [31:0] cfg_wcnt,
  input wire logic cfg_err,
  input wire logic cfg_wr_en,
  input wire logic [8:0] cfg_wr_addr,
  input wire logic [7:0] cfg_wr_data,
  output logic mac_valid,
  output logic [7:0] mac_byte,
  output logic mac_last,
  input wire logic mac_ready,
  input wire logic mac_done,
  input wire logic mac_fail,
  input wire logic [MAC_BYTES*8-1:0] mac_code,
  output logic busy
);
  localparam logic [9:0] MAC_LO = 10'(int'(cbr_pkg::OFS_MAC_TOP) - MAC_BYTES + 1);

  cbr_pkg::cbr_state_t state_q;
  logic [9:0] idx_q;
  logic [8:0] rq_pos_q;
  logic rq_bad_q;
  logic [127:0] rq_nonce_q;
  logic [7:0] rq_type_hi_q;
  logic [127:0] nonce_q;
  logic [31:0] wcnt_q;
  logic err_q;
  logic [15:0] result_q;
  logic [MAC_BYTES*8-1:0] mac_q;
  logic [7:0] byte_q;
  logic cov_q;
  logic req_take;
  logic req_end;
  logic byte_bad;
  logic [15:0] type_cur;
  logic accept;
  logic put_go;

  cbr_mem_if #(.AW(9)) mem ();

  cbr_mem #(.DEPTH(cbr_pkg::CFG_BYTES)) u_mem (
    .clk(clk),
    .ce(ce),
    .mem(mem.store)
  );

  assign mem.wr_en = cfg_wr_en;
  assign mem.wr_addr = cfg_wr_addr;
  assign mem.wr_data = cfg_wr_data;
  // Put state looks one byte ahead, so the one-cycle read state loads fresh data
  assign mem.rd_addr = 9'(idx_q - cbr_pkg::OFS_DATA_LO + ((state_q == cbr_pkg::ST_OUT_PUT) ? 10'h001 : 10'h000));

  // ==========================================================================
  // Frame byte builder
  function automatic logic [7:0] frame_byte(
    input logic [9:0] i,
    input logic [7:0] d,
    input logic [127:0] n,
    input logic [31:0] w,
    input logic [15:0] r,
    input logic [MAC_BYTES*8-1:0] m
  );
    logic [7:0] b;
    b = 8'h00;
    if (i >= cbr_pkg::OFS_DATA_LO) begin
      b = d;
    end else if (i >= MAC_LO && i <= cbr_pkg::OFS_MAC_TOP) begin
      b = m[(int'(cbr_pkg::OFS_MAC_TOP - i))*8 +: 8];
    end else if (i >= cbr_pkg::OFS_NONCE_LO && i <= cbr_pkg::OFS_NONCE_HI) begin
      b = n[(int'(cbr_pkg::OFS_NONCE_HI - i))*8 +: 8];
    end else if (i >= cbr_pkg::OFS_WCNT_LO && i <= cbr_pkg::OFS_WCNT_HI) begin
      b = w[(int'(cbr_pkg::OFS_WCNT_HI - i))*8 +: 8];
    end else if (i == cbr_pkg::OFS_SCNT_HI) begin
      b = cbr_pkg::SCNT_ONE;
    end else if (i == cbr_pkg::OFS_RES_LO) begin
      b = r[15:8];
    end else if (i == cbr_pkg::OFS_RES_HI) begin
      b = r[7:0];
    end else if (i == cbr_pkg::OFS_TYPE_LO) begin
      b = cbr_pkg::RSP_TYPE[15:8];
    end else if (i == cbr_pkg::OFS_TYPE_HI) begin
      b = cbr_pkg::RSP_TYPE[7:0];
    end
    return b;
  endfunction

  // Bytes that feed the code: nonce, address, result, type, data
  function automatic logic mac_covers(input logic [9:0] i);
    return (i >= cbr_pkg::OFS_NONCE_LO && i <= cbr_pkg::OFS_NONCE_HI) ||
           (i >= cbr_pkg::OFS_ADDR_LO && i <= cbr_pkg::OFS_ADDR_HI) ||
           (i >= cbr_pkg::OFS_RES_LO);
  endfunction

  // ==========================================================================
  // Request intake
  assign req_ready = (state_q == cbr_pkg::ST_IDLE) || (state_q == cbr_pkg::ST_HOLD);
  assign req_take = req_valid && req_ready;
  assign req_end = req_take && req_last;
  assign type_cur = {rq_type_hi_q, req_byte};

  always_comb begin
    byte_bad = 1'b0;
    if (rq_pos_q[8]) begin
      byte_bad = 1'b1;
    end else if (10'(rq_pos_q) == cbr_pkg::OFS_SCNT_HI) begin
      byte_bad = (req_byte != cbr_pkg::SCNT_ONE);
    end else if (10'(rq_pos_q) < cbr_pkg::OFS_NONCE_LO || 10'(rq_pos_q) > cbr_pkg::OFS_NONCE_HI) begin
      byte_bad = (10'(rq_pos_q) < cbr_pkg::OFS_TYPE_LO) && (req_byte != 8'h00);
    end
  end

  // Only a whole frame of the read type starts work; other types belong elsewhere
  assign accept = req_end && (10'(rq_pos_q) == cbr_pkg::OFS_TYPE_HI) &&
                  (type_cur == cbr_pkg::REQ_TYPE);

  always_ff @(posedge clk) begin
    if (rst) begin
      rq_pos_q <= 9'h000;
      rq_bad_q <= 1'b0;
      rq_nonce_q <= '0;
      rq_type_hi_q <= 8'h00;
    end else if (ce && req_take) begin
      rq_pos_q <= req_last ? 9'h000 : (rq_pos_q[8] ? rq_pos_q : rq_pos_q + 9'h001);
      rq_bad_q <= req_last ? 1'b0 : (rq_bad_q | byte_bad);
      if (10'(rq_pos_q) >= cbr_pkg::OFS_NONCE_LO && 10'(rq_pos_q) <= cbr_pkg::OFS_NONCE_HI) begin
        rq_nonce_q <= {rq_nonce_q[119:0], req_byte};
      end
      if (10'(rq_pos_q) == cbr_pkg::OFS_TYPE_LO) begin
        rq_type_hi_q <= req_byte;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      send_done <= 1'b0;
    end else if (ce) begin
      send_done <= accept;
    end
  end

  // ==========================================================================
  // Sequencer
  assign put_go = !cov_q || mac_ready;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= cbr_pkg::ST_IDLE;
      idx_q <= 10'h000;
    end else if (ce) begin
      case (state_q)
        cbr_pkg::ST_IDLE, cbr_pkg::ST_HOLD: begin
          if (accept) begin
            state_q <= cbr_pkg::ST_MAC_RD;
            idx_q <= cbr_pkg::OFS_NONCE_LO;
          end else if (state_q == cbr_pkg::ST_HOLD && rcv_cmd) begin
            state_q <= cbr_pkg::ST_OUT_RD;
            idx_q <= 10'h000;
          end
        end
        cbr_pkg::ST_MAC_RD: state_q <= cbr_pkg::ST_MAC_LD;
        cbr_pkg::ST_MAC_LD: state_q <= cbr_pkg::ST_MAC_PUT;
        cbr_pkg::ST_MAC_PUT: begin
          if (put_go) begin
            if (idx_q == cbr_pkg::OFS_DATA_HI) begin
              state_q <= cbr_pkg::ST_MAC_WAIT;
            end else begin
              state_q <= cbr_pkg::ST_MAC_RD;
              idx_q <= idx_q + 10'h001;
            end
          end
        end
        cbr_pkg::ST_MAC_WAIT: begin
          if (mac_done) begin
            state_q <= cbr_pkg::ST_HOLD;
          end
        end
        cbr_pkg::ST_OUT_RD: state_q <= cbr_pkg::ST_OUT_PUT;
        cbr_pkg::ST_OUT_PUT: begin
          if (rsp_ready) begin
            if (idx_q == cbr_pkg::OFS_DATA_HI) begin
              state_q <= cbr_pkg::ST_IDLE;
            end else begin
              state_q <= cbr_pkg::ST_OUT_RD;
              idx_q <= idx_q + 10'h001;
            end
          end
        end
        default: state_q <= cbr_pkg::ST_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // Latched frame fields
  always_ff @(posedge clk) begin
    if (rst) begin
      nonce_q <= '0;
      wcnt_q <= 32'h0000_0000;
    end else if (ce && accept) begin
      nonce_q <= rq_nonce_q;
      wcnt_q <= cfg_wcnt;
    end
  end

  // Errors count in both passes until the result bytes, but result_q follows them only in the code pass, so code and frame agree
  always_ff @(posedge clk) begin
    if (rst) begin
      err_q <= 1'b0;
    end else if (ce) begin
      if (accept) begin
        err_q <= rq_bad_q || cfg_err;
      end else if (state_q != cbr_pkg::ST_HOLD && state_q != cbr_pkg::ST_IDLE && idx_q < cbr_pkg::OFS_RES_LO) begin
        err_q <= err_q | cfg_err;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      result_q <= cbr_pkg::RES_OK;
      mac_q <= '0;
    end else if (ce) begin
      if (state_q == cbr_pkg::ST_MAC_RD || state_q == cbr_pkg::ST_MAC_LD || state_q == cbr_pkg::ST_MAC_PUT) begin
        result_q <= err_q ? cbr_pkg::RES_GEN_FAIL : cbr_pkg::RES_OK;
        mac_q <= '0;
      end else if (state_q == cbr_pkg::ST_MAC_WAIT && mac_done) begin
        if (mac_fail) begin
          result_q <= cbr_pkg::RES_AUTH_FAIL;
        end else begin
          mac_q <= mac_code;
        end
      end
    end
  end

  // ==========================================================================
  // Shared byte register feeding both the code engine and the host
  always_ff @(posedge clk) begin
    if (rst) begin
      byte_q <= 8'h00;
      cov_q <= 1'b0;
    end else if (ce && (state_q == cbr_pkg::ST_MAC_LD || state_q == cbr_pkg::ST_OUT_RD)) begin
      byte_q <= frame_byte(idx_q, mem.rd_data, nonce_q, wcnt_q, result_q, mac_q);
      cov_q <= mac_covers(idx_q);
    end
  end

  // Last flags only with a valid byte, never while idle on the final index
  assign mac_valid = (state_q == cbr_pkg::ST_MAC_PUT) && cov_q;
  assign mac_byte = byte_q;
  assign mac_last = mac_valid && (idx_q == cbr_pkg::OFS_DATA_HI);
  assign rsp_valid = (state_q == cbr_pkg::ST_OUT_PUT);
  assign rsp_byte = byte_q;
  assign rsp_last = rsp_valid && (idx_q == cbr_pkg::OFS_DATA_HI);
  assign busy = (state_q != cbr_pkg::ST_IDLE) && (state_q != cbr_pkg::ST_HOLD);
endmodule

// ==== design/cbr_pkg.sv ====
// Constants, frame layout and state type of the configuration block read responder.
// Assumes frames of 8-bit bytes, byte 0 first, multi-byte fields most significant byte first.
package cbr_pkg;
  // ==========================================================================
  // Message types and result codes
  localparam logic [15:0] REQ_TYPE = 16'h0007;
  localparam logic [15:0] RSP_TYPE = 16'h0700;
  localparam logic [15:0] RES_OK = 16'h0000;
  localparam logic [15:0] RES_GEN_FAIL = 16'h0001;
  localparam logic [15:0] RES_AUTH_FAIL = 16'h0002;
  localparam logic [7:0] SCNT_ONE = 8'h01;
  // ==========================================================================
  // Byte offsets in the frame
  localparam logic [9:0] OFS_MAC_TOP = 10'h0DE;
  localparam logic [9:0] OFS_TARGET = 10'h0DF;
  localparam logic [9:0] OFS_NONCE_LO = 10'h0E0;
  localparam logic [9:0] OFS_NONCE_HI = 10'h0EF;
  localparam logic [9:0] OFS_WCNT_LO = 10'h0F0;
  localparam logic [9:0] OFS_WCNT_HI = 10'h0F3;
  localparam logic [9:0] OFS_ADDR_LO = 10'h0F4;
  localparam logic [9:0] OFS_ADDR_HI = 10'h0F7;
  localparam logic [9:0] OFS_SCNT_HI = 10'h0FB;
  localparam logic [9:0] OFS_RES_LO = 10'h0FC;
  localparam logic [9:0] OFS_RES_HI = 10'h0FD;
  localparam logic [9:0] OFS_TYPE_LO = 10'h0FE;
  localparam logic [9:0] OFS_TYPE_HI = 10'h0FF;
  localparam logic [9:0] OFS_DATA_LO = 10'h100;
  localparam logic [9:0] OFS_DATA_HI = 10'h2FF;
  // ==========================================================================
  // Sizes
  localparam int CFG_BYTES = 512;
  localparam int MAC_BYTES_DEF = 32;
  // ==========================================================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_MAC_RD, ST_MAC_LD, ST_MAC_PUT, ST_MAC_WAIT, ST_HOLD, ST_OUT_RD, ST_OUT_PUT
  } cbr_state_t;
endpackage

// ==== design/cbr_mem_if.sv ====
// Port bundle between the sequencer and the configuration block store.
// Assumes one write port and one registered read port on the same clock.
interface cbr_mem_if #(parameter int AW = 9);
  logic [AW-1:0] rd_addr;
  logic [7:0] rd_data;
  logic wr_en;
  logic [AW-1:0] wr_addr;
  logic [7:0] wr_data;
  modport user (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
  modport store (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface

// ==== design/cbr_mem.sv ====
// Byte store holding the device configuration block.
// Assumes no reset and a clock enable that freezes it; read data one cycle late.
module cbr_mem #(
  parameter int DEPTH = cbr_pkg::CFG_BYTES
) (
  input wire logic clk,
  input wire logic ce,
  cbr_mem_if.store mem
);
  logic [7:0] store_q [DEPTH];
  logic [7:0] rd_q;

  // ==========================================================================
  // Storage, no reset so it maps onto block RAM
  always_ff @(posedge clk) begin
    if (ce && mem.wr_en) begin
      store_q[mem.wr_addr] <= mem.wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      rd_q <= store_q[mem.rd_addr];
    end
  end

  assign mem.rd_data = rd_q;
endmodule

// ==== tb/cbr_sva.sv ====
// Port checks for cbr_top.
// Assumes one clock, synchronous active-high rst.
module cbr_sva (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic req_valid,
  input wire logic req_last,
  input wire logic req_ready,
  input wire logic send_done,
  input wire logic rcv_cmd,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic rsp_last,
  input wire logic rsp_ready,
  input wire logic mac_valid,
  input wire logic [7:0] mac_byte,
  input wire logic mac_last,
  input wire logic mac_ready,
  input wire logic busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================
  // Accepted response bytes
  logic [9:0] n_q;
  always_ff @(posedge clk) begin
    if (rst) n_q <= 10'h000;
    else if (ce && rsp_valid && rsp_ready) n_q <= rsp_last ? 10'h000 : n_q + 10'h001;
  end
  // Accepted code bytes: 536 covered bytes per frame
  logic [9:0] m_q;
  always_ff @(posedge clk) begin
    if (rst) m_q <= 10'h000;
    else if (ce && mac_valid && mac_ready) m_q <= mac_last ? 10'h000 : m_q + 10'h001;
  end
  sequence s_acc; ce && rsp_valid && rsp_ready; endsequence
  sequence s_gap; !rsp_valid ##1 rsp_valid; endsequence
  // ==========================================
  // Properties
  property p_rst; $fell(rst) |-> req_ready && !busy && !send_done && !rsp_valid && !mac_valid; endproperty
  property p_done; send_done |-> $past(req_valid && req_ready && req_last) ##1 !send_done; endproperty
  property p_busy; (busy || rsp_valid || mac_valid) |-> !req_ready && !(rsp_valid && mac_valid); endproperty
  property p_rsp_hold; ce && rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_byte); endproperty
  property p_mac_hold; ce && mac_valid && !mac_ready |=> mac_valid && $stable(mac_byte); endproperty
  property p_start; $rose(rsp_valid) |-> $past(rcv_cmd, 2) || $past(rsp_valid && rsp_ready, 2); endproperty
  property p_next; s_acc ##0 !rsp_last |=> s_gap; endproperty
  property p_last; rsp_valid |-> (rsp_last == (n_q == 10'h2FF)); endproperty
  property p_mac_last; mac_valid |-> (mac_last == (m_q == 10'h217)); endproperty
  a_rst: assert property (p_rst) else $error("reset outputs wrong");
  a_done: assert property (p_done) else $error("send_done without frame end");
  a_busy: assert property (p_busy) else $error("ready while busy");
  a_rsp_hold: assert property (p_rsp_hold) else $error("response byte dropped");
  a_mac_hold: assert property (p_mac_hold) else $error("code byte dropped");
  a_start: assert property (p_start) else $error("response byte too early");
  a_next: assert property (p_next) else $error("response spacing wrong");
  a_last: assert property (p_last) else $error("last flag misplaced");
  a_mac_last: assert property (p_mac_last) else $error("code last misplaced");
endmodule
bind cbr_top cbr_sva u_sva (.clk, .rst, .ce, .req_valid, .req_last, .req_ready, .send_done, .rcv_cmd,
  .rsp_valid, .rsp_byte, .rsp_last, .rsp_ready, .mac_valid, .mac_byte, .mac_last, .mac_ready, .busy);

// ==== tb/cbr_host.sv ====
// Host model: sends request frames, retrieves response frames.
// Assumes falling-edge drive and req_ready/rsp_valid from the block.
module cbr_host (
  input wire logic clk,
  input wire logic req_ready,
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_byte,
  input wire logic rsp_last,
  output logic req_valid,
  output logic [7:0] req_byte,
  output logic req_last,
  output logic rcv_cmd,
  output logic rsp_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] got [768];
  int n_got;
  logic last_ok;
  initial {req_valid, req_byte, req_last, rcv_cmd, rsp_ready} = 12'h000;
  // ==========================================
  // Request frame
  function automatic logic [7:0] rq_byte(int i, logic [127:0] nc, logic [15:0] ty, logic bad);
    if (i >= 224 && i <= 239) return nc[(239-i)*8 +: 8];
    if (i == 254) return ty[15:8];
    if (i == 255) return ty[7:0];
    if (i == 251) return 8'h01;
    if (i == 245) return {7'h00, bad};
    return 8'h00;
  endfunction
  task automatic send(logic [127:0] nc, logic [15:0] ty, logic bad, int len);
    for (int i = 0; i < len; i++) begin
      @(negedge clk);
      req_valid = 1'b1;
      req_byte = rq_byte(i, nc, ty, bad);
      req_last = (i == len - 1);
      do @(posedge clk); while (req_ready !== 1'b1);
    end
    @(negedge clk);
    req_valid = 1'b0;
    req_last = 1'b0;
    req_byte = ~req_byte; // Released: never the old value
  endtask
  // ==========================================
  // Retrieve, optionally stalling
  task automatic fetch(logic slow);
    @(negedge clk);
    rcv_cmd = 1'b1;
    @(negedge clk);
    rcv_cmd = 1'b0;
    n_got = 0;
    last_ok = 1'b1;
    for (int k = 0; k < 6000 && n_got < 768; k++) begin
      rsp_ready = !slow || k[1];
      @(posedge clk);
      if (rsp_valid === 1'b1 && rsp_ready) begin
        got[n_got] = rsp_byte;
        if (rsp_last !== (n_got == 767)) last_ok = 1'b0;
        n_got++;
      end
      @(negedge clk);
    end
    rsp_ready = 1'b0;
  endtask
endmodule

// ==== tb/test_cbr_top.sv ====
// Self-checking bench for cbr_top with host model and code engine.
// Assumes a 4-byte code field; frames stay at the full 768 bytes.
module test_cbr_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int MB = 4;
  typedef struct packed {logic [127:0] nc; logic [31:0] wc; logic er; logic mf; logic bad; logic [15:0] rs;} cbr_row_t;
  cbr_row_t rows [4] = '{'{{8{16'h1F2E}}, 32'h00000003, 1'b0, 1'b0, 1'b0, 16'h0000},
    '{{8{16'hA55A}}, 32'hFFFFFFFE, 1'b0, 1'b1, 1'b0, 16'h0002},
    '{{8{16'h0F0F}}, 32'h12345678, 1'b1, 1'b0, 1'b0, 16'h0001},
    '{{8{16'h7E81}}, 32'h80000001, 1'b0, 1'b0, 1'b1, 16'h0001}};
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, cfg_err = 1'b0, cfg_wr_en = 1'b0, fail_sel = 1'b0;
  logic mac_ready = 1'b0, mac_done = 1'b0, mac_fail = 1'b0, mac_pend = 1'b0;
  logic [8:0] cfg_wr_addr = 9'h000;
  logic [7:0] cfg_wr_data = 8'h00, rsp_byte, req_byte, mac_byte;
  logic [31:0] cfg_wcnt = 32'h00000000;
  logic [MB*8-1:0] mac_code = 32'hA1B2C3D4;
  logic req_valid, req_last, req_ready, send_done, rcv_cmd, rsp_valid, rsp_last, rsp_ready, mac_valid, mac_last, busy;
  int miscompares = 0, cmp_count = 0, n_done = 0, n_mac = 0, mac_sum = 0;
  cbr_top #(.MAC_BYTES(MB)) DUT (.clk, .rst, .ce, .req_valid, .req_byte, .req_last, .req_ready, .send_done,
    .rcv_cmd, .rsp_valid, .rsp_byte, .rsp_last, .rsp_ready, .cfg_wcnt, .cfg_err, .cfg_wr_en, .cfg_wr_addr,
    .cfg_wr_data, .mac_valid, .mac_byte, .mac_last, .mac_ready, .mac_done, .mac_fail, .mac_code, .busy);
  cbr_host u_host (.clk, .req_ready, .rsp_valid, .rsp_byte, .rsp_last, .req_valid, .req_byte, .req_last,
    .rcv_cmd, .rsp_ready);
  initial forever #25 clk = ~clk;
  // ==========================================
  // Code engine: stalls every other cycle
  always @(negedge clk) begin
    mac_ready <= ~mac_ready;
    mac_done <= mac_pend;
    mac_fail <= mac_pend & fail_sel;
  end
  always @(posedge clk) begin
    mac_pend <= mac_valid & mac_ready & mac_last;
    n_mac <= n_mac + int'(mac_valid & mac_ready);
    mac_sum <= mac_sum + (((mac_valid & mac_ready) === 1'b1) ? (n_mac + 1) * int'(mac_byte) : 0);
    n_done <= n_done + int'(send_done === 1'b1);
  end
  // ==========================================
  // Checks
  task automatic chk_byte(logic [7:0] e, logic [7:0] a);
    cmp_count++;
    if (a !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  task automatic chk_int(int e, int a);
    cmp_count++;
    if (a != e) begin
      miscompares++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  function automatic logic [7:0] ex_byte(int i, cbr_row_t r);
    if (i >= 223 - MB && i <= 222) return r.mf ? 8'h00 : mac_code[(222-i)*8 +: 8];
    if (i >= 224 && i <= 239) return r.nc[(239-i)*8 +: 8];
    if (i >= 240 && i <= 243) return r.wc[(243-i)*8 +: 8];
    if (i == 251) return 8'h01;
    if (i == 252) return r.rs[15:8];
    if (i == 253) return r.rs[7:0];
    if (i == 254) return 8'h07;
    if (i >= 256) return 8'(i - 256) ^ 8'h5A;
    return 8'h00;
  endfunction
  task automatic wait_idle();
    for (int k = 0; k < 5000 && busy !== 1'b0; k++) @(negedge clk);
  endtask
  task automatic run_row(cbr_row_t r, logic slow, logic twice);
    int d0, es, nk;
    d0 = n_done;
    cfg_wcnt = r.wc;
    cfg_err = r.er;
    fail_sel = r.mf;
    if (twice) u_host.send(~r.nc, cbr_pkg::REQ_TYPE, 1'b0, 256);
    wait_idle();
    n_mac = 0;
    mac_sum = 0;
    u_host.send(r.nc, cbr_pkg::REQ_TYPE, r.bad, 256);
    wait_idle();
    chk_int(d0 + 1 + int'(twice), n_done);
    chk_int(536, n_mac);
    // Position-weighted sum catches order; engine sees result 0 on its own failure
    es = 0;
    nk = 0;
    for (int i = 224; i < 768; i++) begin
      if (i < 240 || (i >= 244 && i < 248) || i >= 252) begin
        nk++;
        es += nk * int'((i == 253 && r.mf) ? 8'h00 : ex_byte(i, r));
      end
    end
    chk_int(es, mac_sum);
    cfg_wcnt = ~r.wc; // Moves after accept; reply keeps the sampled count
    cfg_err = 1'b0;
    u_host.fetch(slow);
    chk_int(768, u_host.n_got);
    chk_byte(8'h01, {7'h00, u_host.last_ok});
    for (int i = 0; i < 768; i++) chk_byte(ex_byte(i, r), u_host.got[i]);
  endtask
  // ==========================================
  // Sequence
  initial begin
    repeat (12) @(negedge clk);
    chk_byte(8'h10, {3'h0, req_ready, busy, rsp_valid, send_done, mac_valid});
    rst = 1'b0;
    for (int k = 0; k < 512; k++) begin
      @(negedge clk);
      cfg_wr_en = 1'b1;
      cfg_wr_addr = 9'(k);
      cfg_wr_data = 8'(k) ^ 8'h5A;
    end
    @(negedge clk);
    cfg_wr_en = 1'b0;
    for (int j = 0; j < 4; j++) run_row(rows[j], j[0], 1'b0);
    run_row(rows[0], 1'b1, 1'b1);
    u_host.fetch(1'b0);
    chk_int(0, u_host.n_got);
    u_host.send(rows[0].nc, 16'h0006, 1'b0, 256);
    u_host.send(rows[0].nc, cbr_pkg::REQ_TYPE, 1'b0, 100);
    // Frozen block must ignore a whole read frame
    ce = 1'b0;
    u_host.send(rows[0].nc, cbr_pkg::REQ_TYPE, 1'b0, 256);
    ce = 1'b1;
    repeat (4) @(negedge clk);
    chk_int(6, n_done);
    end_of_test();
  end
  initial begin
    #4ms;
    miscompares++;
    end_of_test();
  end
endmodule
